//--- rtl/ppo_pin_sync.sv
// Three-stage input synchroniser per pin; value changes once stages two and three agree
`timescale 1ns/1ps
`include "ppo_regs.svh"
module ppo_pin_sync (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Asynchronous pin levels
    input  wire logic [`PPO_PINS-1:0]   async_in,
    // Synchronised levels
    output logic      [`PPO_PINS-1:0]   sync_out
);

    logic [`PPO_PINS-1:0] s1_q;
    logic [`PPO_PINS-1:0] s2_q;
    logic [`PPO_PINS-1:0] s3_q;
    logic [`PPO_PINS-1:0] out_q;
    logic [`PPO_PINS-1:0] out_d;

    genvar g;
    generate
        for (g = 0; g < `PPO_PINS; g = g + 1) begin : g_bit
            always_comb begin
                out_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : out_q[g];
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (rst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule : ppo_pin_sync

//--- rtl/ppo_pkg.sv
// Types shared by the pin override port
package ppo_pkg;

    typedef logic [7:0] ppo_byte_t;

    typedef enum logic [0:0] {
        PPO_RD_IDLE = 1'b0,
        PPO_RD_RESP = 1'b1
    } ppo_rd_state_e;

    typedef enum logic [0:0] {
        PPO_WR_COLLECT = 1'b0,
        PPO_WR_RESP    = 1'b1
    } ppo_wr_state_e;

endpackage : ppo_pkg

//--- rtl/ppo_port.sv
// One eight-pin port with alternate-function overrides and an AXI4-Lite register slave
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ppo_regs.svh"
module ppo_port (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // AXI4-Lite write address
    input  wire logic [31:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Sleep state from the power controller, shared by all ports
    input  wire logic                   sleep_mode,
    // Per-pin overrides from peripheral modules
    input  wire logic [`PPO_PINS-1:0]   pullup_override_enable,
    input  wire logic [`PPO_PINS-1:0]   pullup_override_value,
    input  wire logic [`PPO_PINS-1:0]   direction_override_enable,
    input  wire logic [`PPO_PINS-1:0]   direction_override_value,
    input  wire logic [`PPO_PINS-1:0]   out_value_override_enable,
    input  wire logic [`PPO_PINS-1:0]   out_value_override_value,
    input  wire logic [`PPO_PINS-1:0]   input_enable_override_enable,
    input  wire logic [`PPO_PINS-1:0]   input_enable_override_value,
    // Paths back to peripheral modules
    output logic      [`PPO_PINS-1:0]   alt_digital_input,
    output logic      [`PPO_PINS-1:0]   analog_pad_path,
    // Pad controls
    input  wire logic [`PPO_PINS-1:0]   pad_in,
    output logic      [`PPO_PINS-1:0]   pad_out,
    output logic      [`PPO_PINS-1:0]   pad_oe_n,
    output logic      [`PPO_PINS-1:0]   pad_pullup_en,
    output logic      [`PPO_PINS-1:0]   pad_input_en
);

    // Port registers
    ppo_pkg::ppo_byte_t out_val_q;
    ppo_pkg::ppo_byte_t out_val_d;
    ppo_pkg::ppo_byte_t dir_q;
    ppo_pkg::ppo_byte_t dir_d;
    ppo_pkg::ppo_byte_t sfc_q;
    ppo_pkg::ppo_byte_t sfc_d;

    // Write channel state
    ppo_pkg::ppo_wr_state_e wr_state_q;
    ppo_pkg::ppo_wr_state_e wr_state_d;
    logic                   aw_have_q;
    logic                   aw_have_d;
    logic                   w_have_q;
    logic                   w_have_d;
    logic [`PPO_DEC_W-1:0]  aw_addr_q;
    logic [`PPO_DEC_W-1:0]  aw_addr_d;
    logic [31:0]            w_data_q;
    logic [31:0]            w_data_d;
    logic [3:0]             w_strb_q;
    logic [3:0]             w_strb_d;
    logic [1:0]             bresp_q;
    logic [1:0]             bresp_d;

    // Read channel state
    ppo_pkg::ppo_rd_state_e rd_state_q;
    ppo_pkg::ppo_rd_state_e rd_state_d;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;
    logic [1:0]             rresp_q;
    logic [1:0]             rresp_d;

    // Pin datapath
    logic                   global_pullup_disable;
    logic [`PPO_PINS-1:0]   drive_en;
    logic [`PPO_PINS-1:0]   schmitt_out;
    logic [`PPO_PINS-1:0]   pin_input_bit;

    // Strobes decoded from the bus are common to all pins of the port
    logic                   write_value_strobe;
    logic                   write_direction_strobe;
    logic                   write_sfc_strobe;
    logic                   read_value_strobe;
    logic                   read_pin_strobe;
    logic                   read_direction_strobe;
    logic                   read_sfc_strobe;
    logic                   wr_fire;
    logic                   wr_hit;
    logic [31:0]            rd_word;
    logic                   rd_hit;

    assign global_pullup_disable = sfc_q[`PPO_PUD_BIT];

    // Pin override logic, purely combinational per pin
    genvar g;
    generate
        for (g = 0; g < `PPO_PINS; g = g + 1) begin : g_pin
            always_comb begin
                if (rst) begin
                    pad_pullup_en[g] = 1'b0;
                end else if (pullup_override_enable[g]) begin
                    pad_pullup_en[g] = pullup_override_value[g];
                end else begin
                    pad_pullup_en[g] = ({dir_q[g], out_val_q[g], global_pullup_disable} == `PPO_PU_SEL);
                end
            end

            always_comb begin
                if (direction_override_enable[g]) begin
                    drive_en[g] = direction_override_value[g];
                end else begin
                    drive_en[g] = dir_q[g];
                end
            end

            always_comb begin
                if (out_value_override_enable[g]) begin
                    pad_out[g] = out_value_override_value[g];
                end else begin
                    pad_out[g] = out_val_q[g];
                end
            end

            always_comb begin
                if (input_enable_override_enable[g]) begin
                    pad_input_en[g] = input_enable_override_value[g];
                end else begin
                    pad_input_en[g] = ~sleep_mode;
                end
            end
        end
    endgenerate

    assign pad_oe_n = ~drive_en;

    // Disabled inputs are clamped low ahead of the Schmitt trigger
    assign schmitt_out       = pad_in & pad_input_en;
    assign alt_digital_input = schmitt_out;
    assign analog_pad_path   = pad_in;

    ppo_pin_sync u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (schmitt_out),
        .sync_out (pin_input_bit)
    );

    // Write address and data are taken in either order, response follows both
    assign s_axi_awready = (wr_state_q == ppo_pkg::PPO_WR_COLLECT) && !aw_have_q;
    assign s_axi_wready  = (wr_state_q == ppo_pkg::PPO_WR_COLLECT) && !w_have_q;
    assign s_axi_bvalid  = (wr_state_q == ppo_pkg::PPO_WR_RESP);
    assign s_axi_bresp   = bresp_q;

    assign wr_fire = aw_have_q && w_have_q && (wr_state_q == ppo_pkg::PPO_WR_COLLECT);

    // Write decode; the pin input register accepts a write and ignores it
    always_comb begin
        wr_hit                 = 1'b0;
        write_value_strobe     = 1'b0;
        write_direction_strobe = 1'b0;
        write_sfc_strobe       = 1'b0;
        case (aw_addr_q)
            `PPO_ADDR_OUT: begin
                wr_hit             = 1'b1;
                write_value_strobe = wr_fire && w_strb_q[0];
            end
            `PPO_ADDR_DIR: begin
                wr_hit                 = 1'b1;
                write_direction_strobe = wr_fire && w_strb_q[0];
            end
            `PPO_ADDR_PIN: begin
                wr_hit = 1'b1;
            end
            `PPO_ADDR_SFC: begin
                wr_hit           = 1'b1;
                write_sfc_strobe = wr_fire && w_strb_q[0];
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        wr_state_d = wr_state_q;
        aw_have_d  = aw_have_q;
        w_have_d   = w_have_q;
        aw_addr_d  = aw_addr_q;
        w_data_d   = w_data_q;
        w_strb_d   = w_strb_q;
        bresp_d    = bresp_q;
        out_val_d  = out_val_q;
        dir_d      = dir_q;
        sfc_d      = sfc_q;
        case (wr_state_q)
            ppo_pkg::PPO_WR_COLLECT: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_have_d = 1'b1;
                    aw_addr_d = s_axi_awaddr[`PPO_DEC_W-1:0];
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_have_d = 1'b1;
                    w_data_d = s_axi_wdata;
                    w_strb_d = s_axi_wstrb;
                end
                if (wr_fire) begin
                    aw_have_d  = 1'b0;
                    w_have_d   = 1'b0;
                    bresp_d    = wr_hit ? `PPO_RESP_OKAY : `PPO_RESP_SLVERR;
                    wr_state_d = ppo_pkg::PPO_WR_RESP;
                end
                if (write_value_strobe) begin
                    out_val_d = w_data_q[7:0];
                end
                if (write_direction_strobe) begin
                    dir_d = w_data_q[7:0];
                end
                if (write_sfc_strobe) begin
                    sfc_d = w_data_q[7:0];
                end
            end
            ppo_pkg::PPO_WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_d = ppo_pkg::PPO_WR_COLLECT;
                end
            end
            default: begin
                wr_state_d = ppo_pkg::PPO_WR_COLLECT;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_state_q <= ppo_pkg::PPO_WR_COLLECT;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            aw_addr_q  <= '0;
            w_data_q   <= '0;
            w_strb_q   <= '0;
            bresp_q    <= `PPO_RESP_OKAY;
            out_val_q  <= `PPO_RST_OUT;
            dir_q      <= `PPO_RST_DIR;
            sfc_q      <= `PPO_RST_SFC;
        end else begin
            wr_state_q <= wr_state_d;
            aw_have_q  <= aw_have_d;
            w_have_q   <= w_have_d;
            aw_addr_q  <= aw_addr_d;
            w_data_q   <= w_data_d;
            w_strb_q   <= w_strb_d;
            bresp_q    <= bresp_d;
            out_val_q  <= out_val_d;
            dir_q      <= dir_d;
            sfc_q      <= sfc_d;
        end
    end

    // Read channel: one cycle from address to data
    assign s_axi_arready = (rd_state_q == ppo_pkg::PPO_RD_IDLE);
    assign s_axi_rvalid  = (rd_state_q == ppo_pkg::PPO_RD_RESP);
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign read_value_strobe     = s_axi_arvalid && s_axi_arready
                                && (s_axi_araddr[`PPO_DEC_W-1:0] == `PPO_ADDR_OUT);
    assign read_direction_strobe = s_axi_arvalid && s_axi_arready
                                && (s_axi_araddr[`PPO_DEC_W-1:0] == `PPO_ADDR_DIR);
    assign read_pin_strobe       = s_axi_arvalid && s_axi_arready
                                && (s_axi_araddr[`PPO_DEC_W-1:0] == `PPO_ADDR_PIN);
    assign read_sfc_strobe       = s_axi_arvalid && s_axi_arready
                                && (s_axi_araddr[`PPO_DEC_W-1:0] == `PPO_ADDR_SFC);

    // Read data selection; an unmapped address reads zero
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b0;
        if (read_value_strobe) begin
            rd_word = {`PPO_ZERO_HI, out_val_q};
            rd_hit  = 1'b1;
        end
        if (read_direction_strobe) begin
            rd_word = {`PPO_ZERO_HI, dir_q};
            rd_hit  = 1'b1;
        end
        if (read_pin_strobe) begin
            rd_word = {`PPO_ZERO_HI, pin_input_bit};
            rd_hit  = 1'b1;
        end
        if (read_sfc_strobe) begin
            rd_word = {`PPO_ZERO_HI, sfc_q};
            rd_hit  = 1'b1;
        end
    end

    always_comb begin
        rd_state_d = rd_state_q;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        case (rd_state_q)
            ppo_pkg::PPO_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_state_d = ppo_pkg::PPO_RD_RESP;
                    rdata_d    = rd_word;
                    rresp_d    = rd_hit ? `PPO_RESP_OKAY : `PPO_RESP_SLVERR;
                end
            end
            ppo_pkg::PPO_RD_RESP: begin
                if (s_axi_rready) begin
                    rd_state_d = ppo_pkg::PPO_RD_IDLE;
                end
            end
            default: begin
                rd_state_d = ppo_pkg::PPO_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_state_q <= ppo_pkg::PPO_RD_IDLE;
            rdata_q    <= '0;
            rresp_q    <= `PPO_RESP_OKAY;
        end else begin
            rd_state_q <= rd_state_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
        end
    end

endmodule : ppo_port

//--- rtl/ppo_regs.svh
// Register map, field positions, reset values and encodings of the pin override port
`ifndef PPO_REGS_SVH
`define PPO_REGS_SVH


`define PPO_PINS        8
`define PPO_DEC_W       8
`define PPO_ADDR_OUT    8'h00
`define PPO_ADDR_DIR    8'h04
`define PPO_ADDR_PIN    8'h08
`define PPO_ADDR_SFC    8'h0c
`define PPO_RST_OUT     8'h00
`define PPO_RST_DIR     8'h00
`define PPO_RST_SFC     8'h00
`define PPO_PUD_BIT     2
`define PPO_PU_SEL      3'b010
`define PPO_RESP_OKAY   2'b00
`define PPO_RESP_SLVERR 2'b10
`define PPO_ZERO_HI     24'h000000

`endif

//--- sim/ppo_periph_model.sv
// Peripheral model: owns the override lines and resynchronises the pad input
`timescale 1ns/1ps
module ppo_periph_model (
    // Clock
    input  wire logic        clock,
    // Requested override pattern and unsynchronised pad input
    input  wire logic [63:0] cfg,
    input  wire logic [7:0]  alt_in,
    // Override lines and resynchronised input
    output logic      [63:0] ovr,
    output logic      [7:0]  alt_sync
);
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    always_ff @(posedge clock) begin
        ovr      <= cfg;
        s1_q     <= alt_in;
        s2_q     <= s1_q;
        alt_sync <= s2_q;
    end
endmodule : ppo_periph_model

//--- sim/ppo_port_sva.sv
// Concurrent checks on the pad controls of the pin override port
`timescale 1ns/1ps
module ppo_port_sva (
    // Clock, reset and sleep state
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       sleep_mode,
    // Read handshake
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    // Overrides from peripherals
    input wire logic [7:0] pullup_override_enable,
    input wire logic [7:0] pullup_override_value,
    input wire logic [7:0] direction_override_enable,
    input wire logic [7:0] direction_override_value,
    input wire logic [7:0] out_value_override_enable,
    input wire logic [7:0] out_value_override_value,
    input wire logic [7:0] input_enable_override_enable,
    input wire logic [7:0] input_enable_override_value,
    // Pad side
    input wire logic [7:0] pad_in,
    input wire logic [7:0] alt_digital_input,
    input wire logic [7:0] analog_pad_path,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] pad_pullup_en,
    input wire logic [7:0] pad_input_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_pu_ovr;
        ((pad_pullup_en ^ pullup_override_value) & pullup_override_enable) == 8'h00;
    endproperty
    a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up ignores override");
    property p_pu_drv;
        (pad_pullup_en & ~pullup_override_enable & ~direction_override_enable & ~pad_oe_n) == 8'h00;
    endproperty
    a_pu_drv: assert property (p_pu_drv) else $error("driven pin pulled up");
    property p_dir_ovr;
        ((~pad_oe_n ^ direction_override_value) & direction_override_enable) == 8'h00;
    endproperty
    a_dir_ovr: assert property (p_dir_ovr) else $error("driver ignores override");
    property p_val_ovr;
        ((pad_out ^ out_value_override_value) & out_value_override_enable & ~pad_oe_n) == 8'h00;
    endproperty
    a_val_ovr: assert property (p_val_ovr) else $error("value ignores override");
    property p_ie_ovr;
        ((pad_input_en ^ input_enable_override_value) & input_enable_override_enable) == 8'h00;
    endproperty
    a_ie_ovr: assert property (p_ie_ovr) else $error("input enable ignores override");
    property p_ie_slp;
        ((pad_input_en ^ {8{!sleep_mode}}) & ~input_enable_override_enable) == 8'h00;
    endproperty
    a_ie_slp: assert property (p_ie_slp) else $error("input enable ignores sleep");
    property p_alt;
        alt_digital_input == (pad_in & pad_input_en) && analog_pad_path == pad_in;
    endproperty
    a_alt: assert property (p_alt) else $error("alternate input paths wrong");
    property p_rst_pu;
        disable iff (1'b0) rst |-> pad_pullup_en == 8'h00;
    endproperty
    a_rst_pu: assert property (p_rst_pu) else $error("pull-up on during reset");

    c_pu_ovr: cover property (|pullup_override_enable && |pad_pullup_en);
    c_sleep:  cover property (sleep_mode && |pad_input_en);
    c_read:   cover property (s_axi_rvalid && s_axi_rready);
endmodule : ppo_port_sva

bind ppo_port ppo_port_sva u_sva (.clock, .rst, .sleep_mode, .s_axi_rvalid, .s_axi_rready,
    .pullup_override_enable, .pullup_override_value, .direction_override_enable,
    .direction_override_value, .out_value_override_enable, .out_value_override_value,
    .input_enable_override_enable, .input_enable_override_value, .pad_in,
    .alt_digital_input, .analog_pad_path, .pad_out, .pad_oe_n, .pad_pullup_en, .pad_input_en);

//--- sim/ppo_port_test.sv
// Self-checking bench of the pin override port
`timescale 1ns/1ps
`include "ppo_regs.svh"
module ppo_port_test;
    logic        clock = 1'b0, rst = 1'b1, sleep_mode = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]  pad_in = 8'h00, alt_digital_input, analog_pad_path, alt_sync;
    logic [7:0]  pad_out, pad_oe_n, pad_pullup_en, pad_input_en;
    logic [63:0] cfg = '0, ovr;
    int          n_fail = 0, num_checks = 0, cyc = 0;

    ppo_periph_model peer (.clock, .cfg, .alt_in(alt_digital_input), .ovr, .alt_sync);
    ppo_port dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep_mode,
        .pullup_override_enable(ovr[7:0]), .pullup_override_value(ovr[15:8]),
        .direction_override_enable(ovr[23:16]), .direction_override_value(ovr[31:24]),
        .out_value_override_enable(ovr[39:32]), .out_value_override_value(ovr[47:40]),
        .input_enable_override_enable(ovr[55:48]), .input_enable_override_value(ovr[63:56]),
        .alt_digital_input, .analog_pad_path, .pad_in, .pad_out, .pad_oe_n, .pad_pullup_en,
        .pad_input_en);

    initial begin
        forever #4 clock = ~clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= {24'h000000, a};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (!aw && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw && w));
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr

    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        axr(`PPO_ADDR_SFC, rd, rs);
        chk(rd, 32'h00000000);
        axw(`PPO_ADDR_OUT, 32'h000000a5, rs);
        axw(`PPO_ADDR_DIR, 32'h0000000f, rs);
        settle();
        chk(pad_pullup_en, 8'ha0);
        chk(pad_oe_n, 8'hf0);
        chk(pad_out & 8'h0f, 8'h05);
        axw(`PPO_ADDR_SFC, 32'h00000004, rs);
        settle();
        chk(pad_pullup_en, 8'h00);
        axr(`PPO_ADDR_SFC, rd, rs);
        chk(rd, 32'h00000004);
        axw(`PPO_ADDR_SFC, 32'h00000000, rs);
        $display("test registers done");
        @(posedge clock);
        cfg <= {8'h05, 8'h0f, 8'h81, 8'hff, 8'ha0, 8'hf0, 8'h3c, 8'hff};
        sleep_mode <= 1'b1;
        pad_in <= 8'h6c;
        settle();
        chk(pad_pullup_en, 8'h3c);
        chk(pad_oe_n, 8'h50);
        chk(pad_out & ~pad_oe_n, 8'h81);
        chk(pad_input_en, 8'h05);
        chk(alt_digital_input, 8'h04);
        chk(analog_pad_path, 8'h6c);
        @(posedge clock);
        sleep_mode <= 1'b0;
        settle();
        chk(pad_input_en, 8'hf5);
        repeat (4) @(posedge clock);
        chk(alt_sync, 8'h64);
        axr(`PPO_ADDR_PIN, rd, rs);
        chk(rd, 32'h00000064);
        $display("test overrides done");
        @(posedge clock);
        cfg <= 64'h00000000_0000ffff;
        settle();
        chk(pad_pullup_en, 8'hff);
        @(posedge clock);
        rst <= 1'b1;
        #1;
        chk(pad_pullup_en, 8'h00);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        axr(`PPO_ADDR_OUT, rd, rs);
        chk(rd, 32'h00000000);
        axr(8'h10, rd, rs);
        chk(rd, 32'h00000000);
        chk({30'h00000000, rs}, {30'h00000000, `PPO_RESP_SLVERR});
        axw(8'h10, 32'h000000ff, rs);
        chk({30'h00000000, rs}, {30'h00000000, `PPO_RESP_SLVERR});
        axw(`PPO_ADDR_PIN, 32'h000000ff, rs);
        chk({30'h00000000, rs}, {30'h00000000, `PPO_RESP_OKAY});
        s_axi_wstrb <= 4'h0;
        axw(`PPO_ADDR_OUT, 32'h000000ff, rs);
        s_axi_wstrb <= 4'hf;
        axr(`PPO_ADDR_OUT, rd, rs);
        chk(rd, 32'h00000000);
        $display("test reset and errors done");
        test_done();
    end
endmodule : ppo_port_test
